// [logic/ibsrc_pkg.sv]
// package: constants for the instrument bus status and remote control block
`default_nettype none
package ibsrc_pkg;
    // =====================================================================
    // bus commands (seven bits, sent with attention true)
    localparam logic [6:0] CMD_GTL     = 7'h01;   // go to local
    localparam logic [6:0] CMD_SDC     = 7'h04;   // selected device clear
    localparam logic [6:0] CMD_GET     = 7'h08;   // group execute trigger
    localparam logic [6:0] CMD_LLO     = 7'h11;   // local lockout
    localparam logic [6:0] CMD_DCL     = 7'h14;   // universal device clear
    localparam logic [6:0] CMD_SPE     = 7'h18;   // serial poll enable
    localparam logic [6:0] CMD_SPD     = 7'h19;   // serial poll disable
    localparam logic [6:0] CMD_UNL     = 7'h3F;   // unlisten
    localparam logic [6:0] CMD_UNT     = 7'h5F;   // untalk
    localparam logic [1:0] GRP_LISTEN  = 2'h1;    // listen address group
    localparam logic [1:0] GRP_TALK    = 2'h2;    // talk address group
    // =====================================================================
    // two-character program codes
    localparam logic [15:0] output_status_code = 16'h4F53;
    localparam logic [15:0] clear_status_code  = 16'h4353;
    localparam logic [15:0] trigger_setup_code = 16'h4354;
    localparam logic [15:0] fire_request_code  = 16'h5452;
    localparam logic [15:0] mask_read_code     = 16'h4F52;
    localparam logic [15:0] mask_load_code     = 16'h4031;
    localparam logic [7:0]  SEP_MAX            = 8'h20;  // blanks and controls
    localparam logic [7:0]  SEP_COMMA          = 8'h2C;
    // =====================================================================
    // status byte layout
    localparam int          SB_EXT_BIT   = 2;        // extended status changed
    localparam int          SB_SVC_BIT   = 6;        // service_flag_bit
    localparam logic [7:0]  SB_LOCAL_ONLY = 8'h03;   // key pressed, entry complete
    localparam logic [7:0]  EXT_VALID    = 8'h7B;    // bits that can ever be set
    localparam logic [7:0]  MASK_RESET   = 8'h00;
    // =====================================================================
    // defaults loaded by the clear action
    localparam logic [31:0] FREQ_KHZ_DEF  = 32'h0089_5440;  // 9000.000 MHz
    localparam logic [15:0] STEPS_DEF     = 16'h0064;       // 100 steps
    localparam logic [31:0] STEP_KHZ_DEF  = 32'h0000_4E20;  // 20.000 MHz
    localparam logic [15:0] DWELL_MS_DEF  = 16'h0014;       // 20 ms
    localparam logic [7:0]  MSG_CLEARED   = 8'h00;
endpackage
`default_nettype wire

// [logic/ibsrc_core.sv]
// module: device-side status, service request and remote control logic
// Operation
// - output status sends status then extended byte
// - output status or clear status clears status
// - extended bit clears after condition gone, readout
// - selected clear when listening, universal always
// - clear: immediate mode, mask, request, trigger, message
// - clear loads frequency, steps, dwell, output defaults
// - trigger ignored unless configured; both forms equal
// - setup code plus one code stored, run
// - remote at first listen address with enable
// - go to local while listening drops remote
// - lockout disables local key, armed from local
// - lockout left only by local or enable
// - enable false gives full local, no lockout
// - enabled conditions request service
// - request in local or remote, lamp lit
// - output status or clear status withdraws request
// - mask load code plus byte, applied at once
// - mask zero at power on
// - mask readback one byte with end flag
// - serial poll byte, bit six service flag
// - service flag only for present enabled conditions
// - status bit two marks extended change
// - status frozen while request stands, events buffered
// - poll end clears status, buffer kept
`default_nettype none
module ibsrc_core (
    input  wire logic        clock,
    input  wire logic        rst,
    // bus lines, true = asserted; outputs pull the line when enable high
    input  wire logic [7:0]  dio_in,
    output logic      [7:0]  dio_out,
    output logic             dio_oe,
    input  wire logic        dav_in,
    output logic             dav_oe,
    input  wire logic        nrfd_in,
    output logic             nrfd_oe,
    input  wire logic        ndac_in,
    output logic             ndac_oe,
    output logic             eoi_oe,
    input  wire logic        atn_in,
    input  wire logic        ifc_in,
    input  wire logic        ren_in,
    output logic             srq_oe,
    input  wire logic [4:0]  bus_addr,
    // instrument side, same clock
    input  wire logic [7:0]  cond_event,
    input  wire logic [7:0]  ext_cond,
    input  wire logic        local_key,
    output logic             remote_lamp,
    output logic             listen_lamp,
    output logic             talk_lamp,
    output logic             service_lamp,
    output logic             lockout,
    output logic             clear_pulse,
    output logic             trig_fire,
    output logic      [15:0] trig_code,
    output logic      [7:0]  request_mask,
    output logic             exec_immediate,
    output logic      [7:0]  message_code,
    output logic      [31:0] freq_khz,
    output logic      [15:0] step_count,
    output logic      [31:0] step_khz,
    output logic      [15:0] dwell_ms,
    output logic             sweep_on,
    output logic             rf_on,
    output logic             mod_on
);
    // =====================================================================
    // input synchronisers: every bus pin and the address pass two flip-flops
    localparam int SW = 19;
    logic [SW-1:0] sync1_q, sync2_q;     // first stage read only by second
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {bus_addr, ren_in, ifc_in, atn_in, ndac_in, nrfd_in, dav_in, dio_in};
            sync2_q <= sync1_q;
        end
    end
    logic [7:0] dio_s;
    logic       dav_s, nrfd_s, ndac_s, atn_s, ifc_s, ren_s;
    logic [4:0] addr_s;
    assign {addr_s, ren_s, ifc_s, atn_s, ndac_s, nrfd_s, dav_s, dio_s} = sync2_q;

    // =====================================================================
    // acceptor handshake
    typedef enum logic [1:0] {
        ACC_READY = 2'b00,   // ready for data, not accepted
        ACC_TAKEN = 2'b01    // byte latched, waiting for data valid to drop
    } ibsrc_acc_t;
    ibsrc_acc_t acc_q;
    logic       lad_q, tad_q;            // listen and talk addressed
    logic       rx_stb;                  // one-cycle strobe for a new byte
    logic       acc_on;
    assign acc_on = atn_s | lad_q;
    assign rx_stb = acc_on && acc_q == ACC_READY && dav_s;
    // not ready while holding a byte; ndac pulled until taken
    assign nrfd_oe = acc_on && acc_q == ACC_TAKEN;
    assign ndac_oe = acc_on && acc_q == ACC_READY;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) acc_q <= ACC_READY;
        else begin
            case (acc_q)
                ACC_READY: if (rx_stb) acc_q <= ACC_TAKEN;
                ACC_TAKEN: if (!dav_s) acc_q <= ACC_READY;
                default:   acc_q <= ACC_READY;
            endcase
        end
    end

    // =====================================================================
    // command decode
    function automatic logic is_cmd(input logic [7:0] b, input logic [6:0] c);
        is_cmd = (b[6:0] == c);
    endfunction
    logic cmd, dat;
    assign cmd = rx_stb & atn_s;
    assign dat = rx_stb & ~atn_s & lad_q;
    localparam logic [1:0] GRP_LISTEN_L = ibsrc_pkg::GRP_LISTEN;
    localparam logic [1:0] GRP_TALK_L   = ibsrc_pkg::GRP_TALK;
    logic my_mla, my_mta, oth_mta;
    assign my_mla  = cmd && dio_s[6:5] == GRP_LISTEN_L && dio_s[4:0] == addr_s;
    assign my_mta  = cmd && dio_s[6:5] == GRP_TALK_L && dio_s[4:0] == addr_s;
    assign oth_mta = cmd && dio_s[6:5] == GRP_TALK_L && dio_s[4:0] != addr_s;
    logic gtl, dev_clear, get_cmd, llo, spe, spd, unt;
    assign gtl       = is_cmd(dio_s, ibsrc_pkg::CMD_GTL) & cmd & lad_q;
    assign dev_clear = cmd & (is_cmd(dio_s, ibsrc_pkg::CMD_DCL)
                     | (is_cmd(dio_s, ibsrc_pkg::CMD_SDC) & lad_q));
    assign get_cmd   = cmd & lad_q & is_cmd(dio_s, ibsrc_pkg::CMD_GET);
    assign llo       = cmd & is_cmd(dio_s, ibsrc_pkg::CMD_LLO);
    assign spe       = cmd & is_cmd(dio_s, ibsrc_pkg::CMD_SPE);
    assign spd       = cmd & is_cmd(dio_s, ibsrc_pkg::CMD_SPD);
    assign unt       = cmd & is_cmd(dio_s, ibsrc_pkg::CMD_UNT);

    // addressing state; interface clear unaddresses everything
    logic spe_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lad_q <= 1'b0;
            tad_q <= 1'b0;
            spe_q <= 1'b0;
        end else if (ifc_s) begin
            lad_q <= 1'b0;
            tad_q <= 1'b0;
            spe_q <= 1'b0;
        end else begin
            // own talk address unlistens, so no self echo
            if (my_mla) lad_q <= 1'b1;
            else if (my_mta || (cmd && is_cmd(dio_s, ibsrc_pkg::CMD_UNL))) lad_q <= 1'b0;
            if (my_mta) tad_q <= 1'b1;
            else if (unt || oth_mta) tad_q <= 1'b0;
            if (spe) spe_q <= 1'b1;
            else if (spd) spe_q <= 1'b0;
        end
    end

    // =====================================================================
    // program code parser: pairs of characters, blanks skipped
    logic [7:0]  first_q;
    logic        have_first_q, mask_next_q, su_next_q;
    logic        code_stb;
    logic [15:0] code;
    logic        sep;
    assign sep      = dio_s <= ibsrc_pkg::SEP_MAX || dio_s == ibsrc_pkg::SEP_COMMA;
    assign code     = {first_q, dio_s};
    assign code_stb = dat && !mask_next_q && !sep && have_first_q;
    logic st_code, cs_code, or_code, fr_code;
    assign st_code = code_stb && !su_next_q && code == ibsrc_pkg::output_status_code;
    assign cs_code = code_stb && !su_next_q && code == ibsrc_pkg::clear_status_code;
    assign or_code = code_stb && !su_next_q && code == ibsrc_pkg::mask_read_code;
    assign fr_code = code_stb && !su_next_q && code == ibsrc_pkg::fire_request_code;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            first_q      <= 8'h00;
            have_first_q <= 1'b0;
            mask_next_q  <= 1'b0;
            su_next_q    <= 1'b0;
        end else if (dat) begin
            if (mask_next_q) mask_next_q <= 1'b0;    // binary byte, no terminator
            else if (!sep) begin
                have_first_q <= !have_first_q;
                first_q      <= dio_s;
                if (code_stb) begin
                    su_next_q   <= !su_next_q && code == ibsrc_pkg::trigger_setup_code;
                    mask_next_q <= !su_next_q && code == ibsrc_pkg::mask_load_code;
                end
            end
        end
    end

    // mask register: power-on zero, loaded at once, zeroed by clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) request_mask <= ibsrc_pkg::MASK_RESET;
        else if (dev_clear) request_mask <= ibsrc_pkg::MASK_RESET;
        else if (dat && mask_next_q) request_mask <= dio_s;
    end

    // =====================================================================
    // trigger configuration and execution
    logic trig_valid_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trig_valid_q <= 1'b0;
            trig_code    <= 16'h0000;
            trig_fire    <= 1'b0;
        end else begin
            trig_fire <= trig_valid_q && (get_cmd || fr_code);
            if (dev_clear) trig_valid_q <= 1'b0;
            else if (code_stb && su_next_q) begin
                trig_valid_q <= 1'b1;
                trig_code    <= code;
            end
        end
    end

    // clear action defaults, also the power-on state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) clear_pulse <= 1'b0;
        else     clear_pulse <= dev_clear;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            exec_immediate <= 1'b1;
            message_code   <= ibsrc_pkg::MSG_CLEARED;
            freq_khz       <= ibsrc_pkg::FREQ_KHZ_DEF;
            step_count     <= ibsrc_pkg::STEPS_DEF;
            step_khz       <= ibsrc_pkg::STEP_KHZ_DEF;
            dwell_ms       <= ibsrc_pkg::DWELL_MS_DEF;
            sweep_on       <= 1'b0;
            rf_on          <= 1'b1;
            mod_on         <= 1'b0;
        end else if (dev_clear) begin
            exec_immediate <= 1'b1;
            message_code   <= ibsrc_pkg::MSG_CLEARED;
            freq_khz       <= ibsrc_pkg::FREQ_KHZ_DEF;
            step_count     <= ibsrc_pkg::STEPS_DEF;
            step_khz       <= ibsrc_pkg::STEP_KHZ_DEF;
            dwell_ms       <= ibsrc_pkg::DWELL_MS_DEF;
            sweep_on       <= 1'b0;
            rf_on          <= 1'b1;
            mod_on         <= 1'b0;
        end
    end

    // =====================================================================
    // remote / local state machine
    typedef enum logic [1:0] {
        RL_LOCAL  = 2'b00,
        RL_REMOTE = 2'b01,
        RL_RWLS   = 2'b10    // remote with lockout
    } ibsrc_rl_t;
    ibsrc_rl_t rl_q;
    logic      llo_armed_q;      // lockout seen in any state, held until enable drops, waits for listen
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rl_q        <= RL_LOCAL;
            llo_armed_q <= 1'b0;
        end else if (!ren_s) begin
            rl_q        <= RL_LOCAL;
            llo_armed_q <= 1'b0;
        end else begin
            if (llo) llo_armed_q <= 1'b1;
            case (rl_q)
                RL_LOCAL:
                    if (my_mla) rl_q <= (llo_armed_q || llo) ? RL_RWLS : RL_REMOTE;
                RL_REMOTE:
                    if (gtl || local_key) rl_q <= RL_LOCAL;
                    else if (llo) rl_q <= RL_RWLS;
                RL_RWLS:
                    if (gtl) rl_q <= RL_LOCAL;
                default: rl_q <= RL_LOCAL;
            endcase
        end
    end
    assign remote_lamp = rl_q != RL_LOCAL;
    assign lockout     = rl_q == RL_RWLS;
    assign listen_lamp = lad_q;
    assign talk_lamp   = tad_q;

    // =====================================================================
    // talker: serial poll, output status, mask readback
    typedef enum logic [1:0] {
        TS_NONE = 2'b00,
        TS_ST   = 2'b01,
        TS_OR   = 2'b10
    } ibsrc_ts_t;
    typedef enum logic [1:0] {
        SRC_IDLE  = 2'b00,
        SRC_SETUP = 2'b01,
        SRC_DAV   = 2'b10
    } ibsrc_src_t;
    ibsrc_ts_t  ts_q;
    ibsrc_src_t src_q;
    logic       idx_q, sp_sent_q;
    logic [7:0] sb_q, buf_q, ext_q;
    logic       srq_q;
    logic       can_talk, byte_done, st_done;
    assign can_talk  = tad_q && !atn_s && (spe_q ? !sp_sent_q : ts_q != TS_NONE);
    assign byte_done = src_q == SRC_DAV && !ndac_s;
    assign st_done   = byte_done && !spe_q && ts_q == TS_ST && idx_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            src_q   <= SRC_IDLE;
            dio_out <= 8'h00;
            eoi_oe  <= 1'b0;
        end else if (atn_s || !tad_q) begin
            src_q  <= SRC_IDLE;
            eoi_oe <= 1'b0;
        end else begin
            case (src_q)
                SRC_IDLE: if (can_talk) begin
                    src_q <= SRC_SETUP;
                    if (spe_q) dio_out <= {sb_q[7], srq_q, sb_q[5:0]};
                    else if (ts_q == TS_OR) dio_out <= request_mask;
                    else dio_out <= idx_q ? ext_q : {sb_q[7], srq_q, sb_q[5:0]};
                    eoi_oe <= !spe_q && (ts_q == TS_OR || idx_q);
                end
                SRC_SETUP: if (!nrfd_s) src_q <= SRC_DAV;
                SRC_DAV:   if (!ndac_s) src_q <= SRC_IDLE;
                default:   src_q <= SRC_IDLE;
            endcase
        end
    end
    assign dio_oe = src_q != SRC_IDLE;
    assign dav_oe = src_q == SRC_DAV;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ts_q      <= TS_NONE;
            idx_q     <= 1'b0;
            sp_sent_q <= 1'b0;
        end else begin
            if (st_code) ts_q <= TS_ST;
            else if (or_code) ts_q <= TS_OR;
            else if (byte_done && !spe_q && (ts_q == TS_OR || idx_q)) ts_q <= TS_NONE;
            if (st_code || or_code) idx_q <= 1'b0;
            else if (byte_done && !spe_q) idx_q <= !idx_q;
            if (!spe_q) sp_sent_q <= 1'b0;
            else if (byte_done) sp_sent_q <= 1'b1;
        end
    end

    // =====================================================================
    // status byte, buffer and service request
    logic [7:0] ev;
    logic [7:0] ext_live;
    logic       ext_chg, sb_clr, poll_end;
    assign ext_live = ext_cond & ibsrc_pkg::EXT_VALID;
    assign ext_chg  = (ext_q | ext_live) != ext_q;
    localparam int SB_SVC = ibsrc_pkg::SB_SVC_BIT;
    localparam int SB_EXT = ibsrc_pkg::SB_EXT_BIT;
    always_comb begin
        ev = cond_event;
        ev[SB_SVC] = 1'b0;
        ev[SB_EXT] = cond_event[SB_EXT] | ext_chg;
        if (rl_q != RL_LOCAL) ev = ev & ~ibsrc_pkg::SB_LOCAL_ONLY;
    end
    assign sb_clr   = st_done || cs_code;
    assign poll_end = sp_sent_q && (spd || ifc_s || unt || oth_mta);
    // extended bits stick until an output status finds the cause gone
    always_ff @(posedge clock or posedge rst) begin
        if (rst) ext_q <= 8'h00;
        else if (st_done) ext_q <= ext_live;
        else ext_q <= ext_q | ext_live;
    end
    // new events win over any clear in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sb_q  <= 8'h00;
            buf_q <= 8'h00;
            srq_q <= 1'b0;
        end else if (sb_clr || poll_end) begin
            sb_q  <= buf_q | ev;
            buf_q <= 8'h00;
            srq_q <= |((buf_q | ev) & request_mask);
        end else if (dev_clear) begin
            sb_q  <= sb_q | ev;
            srq_q <= 1'b0;
        end else if (srq_q) begin
            buf_q <= buf_q | ev;
        end else begin
            sb_q  <= sb_q | ev;
            srq_q <= |((sb_q | ev) & request_mask);
        end
    end
    assign srq_oe       = srq_q;
    assign service_lamp = srq_q;
endmodule
`default_nettype wire

// [verification/ibsrc_core_properties.sv]
// checker: port properties of the status and remote block
`default_nettype none
module ibsrc_core_properties (
    input wire logic        clock, rst, dio_oe, dav_oe, eoi_oe, ren_in, srq_oe,
    input wire logic        remote_lamp, listen_lamp, lockout, service_lamp, rf_on,
    input wire logic        clear_pulse, trig_fire, exec_immediate, mod_on,
    input wire logic [7:0]  dio_out, request_mask, message_code,
    input wire logic [15:0] dwell_ms,
    input wire logic [31:0] freq_khz
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // ====
    // clear action, one cycle after the pulse
    clear_ctl_a: assert property (clear_pulse |=> exec_immediate && !srq_oe
        && request_mask == 8'h00 && message_code == ibsrc_pkg::MSG_CLEARED)
        else $error("clear left control state");
    clear_def_a: assert property (clear_pulse |=> rf_on && !mod_on
        && freq_khz == ibsrc_pkg::FREQ_KHZ_DEF && dwell_ms == ibsrc_pkg::DWELL_MS_DEF)
        else $error("clear left wrong defaults");
    // ====
    // remote state; enable passes a two-stage sync, so four low cycles suffice
    ren_local_a: assert property (!ren_in [*4] |=> !remote_lamp && !lockout)
        else $error("remote held without enable");
    remote_listen_a: assert property ($rose(remote_lamp) |-> ##[0:1] listen_lamp)
        else $error("remote without listen address");
    // ====
    // service request
    srq_lamp_a: assert property ($rose(srq_oe) |-> ##[0:1] service_lamp)
        else $error("service lamp dark");
    srq_mask_a: assert property (srq_oe |-> request_mask != 8'h00)
        else $error("request with empty mask");
    // ====
    // talker side
    eoi_data_a: assert property ($rose(eoi_oe) |-> dio_oe)
        else $error("end flag without data");
    dav_hold_a: assert property (
        dav_oe && $past(dav_oe) |-> dio_oe && $stable(dio_out))
        else $error("data moved under strobe");
    srq_c: cover property ($rose(srq_oe));
    fire_c: cover property (trig_fire);
    eoi_c: cover property ($rose(eoi_oe));
endmodule
`default_nettype wire

// [verification/ibsrc_ctl_model.sv]
// partner: bus controller model, byte source and acceptor on wired lines
`default_nettype none
module ibsrc_ctl_model (
    input  wire logic       clock, dio_oe, dav_oe, nrfd_oe, ndac_oe, eoi_oe,
    input  wire logic [7:0] dio_out,
    output logic      [7:0] dio_in,
    output logic            dav_in, nrfd_in, ndac_in, atn_in, ifc_in, ren_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] dio_q;               // controller pull on data lines
    logic       dav_q, nrfd_q, ndac_q;
    // asserted wins; a released line falls back to false via its pull-up
    assign dio_in  = dio_q | (dio_oe ? dio_out : 8'h00);
    assign dav_in  = dav_q | dav_oe;
    assign nrfd_in = nrfd_q | nrfd_oe;
    assign ndac_in = ndac_q | ndac_oe;
    initial begin
        {dio_q, dav_q, atn_in, ifc_in, ren_in} = '0;
        {nrfd_q, ndac_q} = 2'b11;
    end
    // source a byte; waits for the take before release, not only ndac
    task automatic send(input logic atn, input logic [7:0] b);
        @(negedge clock);
        {nrfd_q, ndac_q} = 2'b00;
        atn_in = atn;
        dio_q = b;
        @(negedge clock);
        for (int i = 0; i < 99 && nrfd_in; i++) @(negedge clock);
        dav_q = 1'b1;
        for (int i = 0; i < 99 && !(nrfd_in && !ndac_in); i++) @(negedge clock);
        dav_q = 1'b0;
        dio_q = 8'h00;
        {nrfd_q, ndac_q} = 2'b11;
        repeat (4) @(negedge clock);
    endtask
    // accept one byte from the device with its end flag
    task automatic recv(output logic [7:0] b, output logic e);
        @(negedge clock);
        atn_in = 1'b0;
        nrfd_q = 1'b0;
        for (int i = 0; i < 99 && !dav_in; i++) @(negedge clock);
        b = dio_in;
        e = eoi_oe;
        {nrfd_q, ndac_q} = 2'b10;
        for (int i = 0; i < 99 && dav_in; i++) @(negedge clock);
        ndac_q = 1'b1;
    endtask
endmodule
`default_nettype wire

// [verification/ibsrc_core_tb_top.sv]
// testbench: drives the controller model and judges the block's answers
`default_nettype none
module ibsrc_core_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] MY_LISTEN = {ibsrc_pkg::GRP_LISTEN, 5'h05};
    localparam logic [6:0] MY_TALK   = {ibsrc_pkg::GRP_TALK, 5'h05};
    logic        clock = 1'b0, rst = 1'b1, local_key = 1'b0;
    logic [4:0]  bus_addr = 5'h05;
    logic [7:0]  cond_event = 8'h00, ext_cond = 8'h00;
    logic        dio_oe, dav_oe, nrfd_oe, ndac_oe, eoi_oe, srq_oe, dav_in, nrfd_in;
    logic        ndac_in, atn_in, ifc_in, ren_in, remote_lamp, listen_lamp, talk_lamp;
    logic        service_lamp, lockout, clear_pulse, trig_fire, exec_immediate;
    logic        sweep_on, rf_on, mod_on;
    logic [7:0]  dio_in, dio_out, request_mask, message_code;
    logic [15:0] trig_code, step_count, dwell_ms;
    logic [31:0] freq_khz, step_khz;
    int          n_fail = 0, total_checks = 0, cycles = 0, fires = 0, clears = 0;
    ibsrc_core      ibsrc_core_i (.*);
    ibsrc_ctl_model ibsrc_ctl_model_i (.*);
    always #5 clock = ~clock;
    // pulse counters and hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        fires <= fires + (trig_fire === 1'b1);
        clears <= clears + (clear_pulse === 1'b1);
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            conclude();
        end
    end
    task automatic check(input string what, input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmd(input logic [6:0] c);
        ibsrc_ctl_model_i.send(1'b1, {1'b0, c});
    endtask
    task automatic code(input logic [15:0] c);
        ibsrc_ctl_model_i.send(1'b0, c[15:8]);
        ibsrc_ctl_model_i.send(1'b0, c[7:0]);
    endtask
    task automatic ev(input logic [7:0] e);
        cond_event = e;
        @(negedge clock);
        cond_event = 8'h00;
        repeat (3) @(negedge clock);
    endtask
    // output status readout: two bytes, end flag on the second
    task automatic st_read(input logic [7:0] s, x);
        logic [7:0] b;
        logic       e;
        cmd(MY_LISTEN);
        code(ibsrc_pkg::output_status_code);
        cmd(MY_TALK);
        ibsrc_ctl_model_i.recv(b, e);
        check("status", {b, e}, {s, 1'b0});
        ibsrc_ctl_model_i.recv(b, e);
        check("extended", {b, e}, {x, 1'b1});
        cmd(ibsrc_pkg::CMD_UNT);
    endtask
    // ====
    // remote, local and lockout
    task automatic s_remote;
        ibsrc_ctl_model_i.ren_in = 1'b1;
        cmd(MY_LISTEN);
        check("remote", remote_lamp, 1'b1);
        cmd(ibsrc_pkg::CMD_UNL);
        cmd(ibsrc_pkg::CMD_GTL);
        check("gtl unaddressed", remote_lamp, 1'b1);
        cmd(MY_LISTEN);
        cmd(ibsrc_pkg::CMD_GTL);
        check("gtl", {remote_lamp, listen_lamp}, 2'b01);
        cmd(ibsrc_pkg::CMD_LLO);
        cmd(ibsrc_pkg::CMD_UNL);
        cmd(MY_LISTEN);
        ev(8'h00);
        local_key = 1'b1;
        ev(8'h00);
        local_key = 1'b0;
        check("lockout", {remote_lamp, lockout}, 2'b11);
        ibsrc_ctl_model_i.ren_in = 1'b0;
        repeat (5) @(negedge clock);
        check("ren off", {remote_lamp, lockout}, 2'b00);
    endtask
    // ====
    // mask, request, poll and status readout, all in local
    task automatic s_status;
        logic [7:0] b;
        logic       e;
        code(ibsrc_pkg::mask_load_code);
        ibsrc_ctl_model_i.send(1'b0, 8'h11);
        check("mask", request_mask, 8'h11);
        ev(8'h02);
        check("unmasked", srq_oe, 1'b0);
        ev(8'h10);
        check("srq", {srq_oe, service_lamp}, 2'b11);
        ev(8'h01);
        cmd(ibsrc_pkg::CMD_SPE);
        cmd(MY_TALK);
        check("talk", {talk_lamp, listen_lamp}, 2'b10);
        ibsrc_ctl_model_i.recv(b, e);
        check("poll", {b, e}, {8'h52, 1'b0});
        cmd(ibsrc_pkg::CMD_SPD);
        check("buffered", srq_oe, 1'b1);
        cmd(ibsrc_pkg::CMD_UNT);
        st_read(8'h41, 8'h00);
        check("withdrawn", srq_oe, 1'b0);
        ext_cond = 8'h08;
        ev(8'h00);
        ext_cond = 8'h00;
        st_read(8'h04, 8'h08);
        st_read(8'h00, 8'h00);
        cmd(MY_LISTEN);
        code(ibsrc_pkg::mask_read_code);
        cmd(MY_TALK);
        ibsrc_ctl_model_i.recv(b, e);
        check("mask read", {b, e}, {8'h11, 1'b1});
        cmd(ibsrc_pkg::CMD_UNT);
    endtask
    // ====
    // trigger setup and both clear forms
    task automatic s_trigger;
        int f;
        int c;
        f = fires;
        c = clears;
        cmd(MY_LISTEN);
        code(ibsrc_pkg::fire_request_code);
        cmd(ibsrc_pkg::CMD_GET);
        check("no setup", fires, f);
        code(ibsrc_pkg::trigger_setup_code);
        code(16'h5736);
        check("trig code", trig_code, 16'h5736);
        cmd(ibsrc_pkg::CMD_GET);
        code(ibsrc_pkg::fire_request_code);
        check("fires", fires, f + 2);
        ev(8'h10);
        cmd(ibsrc_pkg::CMD_UNL);
        cmd(ibsrc_pkg::CMD_SDC);
        check("sdc unaddressed", clears, c);
        cmd(ibsrc_pkg::CMD_DCL);
        check("dcl", {srq_oe, request_mask}, 9'h000);
        check("steps", {sweep_on, step_count}, {1'b0, ibsrc_pkg::STEPS_DEF});
        cmd(MY_LISTEN);
        cmd(ibsrc_pkg::CMD_GET);
        cmd(ibsrc_pkg::CMD_SDC);
        check("erased", fires, f + 2);
        check("clears", clears, c + 2);
    endtask
    initial begin
        repeat (4) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        check("reset mask", request_mask, 8'h00);
        s_remote();
        s_status();
        s_trigger();
        conclude();
    end
endmodule
bind ibsrc_core ibsrc_core_properties ibsrc_core_properties_i (.*);
`default_nettype wire
